// *** core/dmdd_core.sv ***
// Multiplier, scaler, 40-bit accumulator adder with clamping, and iterative divider.
// Assumes the decoder issues one operation per cycle and supplies the repeat count.
//
// Chosen here: the strobed register port and the placing of the registers.

// Operation
// - Divide finishes over 18 step executions
// - Divide steps act on iteration counter value
// - Word divides extend dividend on first step
// - Quotient and remainder land in own registers
// - Long divide uses upper:lower register pair
// - Operands extend to 17 bits before multiply
// - 33-bit product sign-extends to 40 bits
// - Fractional mode gives 1.31 aligned product
// - Integer multiply mixed sign, byte or word
// - Selected accumulator is source and destination
// - Add and load operand pass barrel shifter
// - Subtract complements data, carry is borrow
// - Guard flag follows bits 32 to 39
// - Guard flag with enable requests trap
// - Clamp stickies set by hardware only
// - Unclamped sticky records bit 39, traps
// - Combined guard and clamp status bits
// - 40-bit mode clamps to 9.31 extremes
// - 32-bit mode clamps 1.31, no guard
// - Wrap mode wraps and sets sticky
// - Clamp enables bits 7,6, width bit 4
// - Config selects multiply; round and write clamp bits have no effect
module dmdd_core (
  input  wire logic               clock,
  input  wire logic               srst,
  input  wire logic               opValid,
  input  wire dmdd_pkg::dmdd_op_t op,
  input  wire logic [4:0]         iterationCounter,
  input  wire logic [3:0]         regAddr,
  input  wire logic [15:0]        regWdata,
  input  wire logic               regWrite,
  input  wire logic               regRead,
  output logic      [15:0]        regRdata,
  output logic      [15:0]        quotientReg,
  output logic      [15:0]        remainderReg,
  output logic      [31:0]        productReg,
  output logic      [15:0]        coreConfig,
  output logic                    trapRequest
);
  logic [15:0] cfg_reg;
  logic [15:0] trap_reg;
  logic [39:0] accumulator_a_reg;
  logic [39:0] accumulator_b_reg;
  logic        guardA_reg;
  logic        guardB_reg;
  logic        clampA_reg;
  logic        clampB_reg;
  logic [15:0] divRem_reg;
  logic [15:0] divLow_reg;
  logic [15:0] divisor_reg;
  logic        negQuot_reg;
  logic        negRem_reg;

  wire logic isAcc = opValid && op.kind inside {dmdd_pkg::OP_MAC, dmdd_pkg::OP_MSC,
    dmdd_pkg::OP_MPY, dmdd_pkg::OP_MPYN, dmdd_pkg::OP_ADDSH, dmdd_pkg::OP_LOAD,
    dmdd_pkg::OP_ADDAB, dmdd_pkg::OP_SUBAB, dmdd_pkg::OP_NEG, dmdd_pkg::OP_CLR};
  wire logic isDiv = opValid && op.kind == dmdd_pkg::OP_DIV;
  wire logic stWrite = regWrite && regAddr == dmdd_pkg::OFS_STATUS;

  // Multiplier
  logic        mulASigned;
  logic        mulBSigned;
  logic [16:0] mulA;
  logic [16:0] mulB;
  logic [33:0] mulFull;
  logic [32:0] product33;
  logic [39:0] product40;
  always_comb begin
    if (op.kind == dmdd_pkg::OP_IMUL) begin
      mulASigned = op.aSigned;
      mulBSigned = op.bSigned;
    end else begin
      mulASigned = !cfg_reg[dmdd_pkg::CFG_UNSIGNED_BIT];
      mulBSigned = !cfg_reg[dmdd_pkg::CFG_UNSIGNED_BIT];
    end
    if (op.kind == dmdd_pkg::OP_IMUL && op.byteMode) begin
      mulA = {{9{mulASigned & op.opA[7]}}, op.opA[7:0]};
      mulB = {{9{mulBSigned & op.opB[7]}}, op.opB[7:0]};
    end else begin
      mulA = {mulASigned & op.opA[15], op.opA};
      mulB = {mulBSigned & op.opB[15], op.opB};
    end
    mulFull = 34'($signed(mulA) * $signed(mulB));
    if (op.kind != dmdd_pkg::OP_IMUL && !cfg_reg[dmdd_pkg::CFG_INTEGER_BIT])
      product33 = {mulFull[31:0], 1'b0};
    else
      product33 = mulFull[32:0];
    product40 = {{7{product33[32]}}, product33};
  end

  // Operand scaling for add and load
  logic signed [39:0] wordIn;
  logic signed [39:0] shifted;
  always_comb begin
    wordIn = {{8{op.opA[15]}}, op.opA, 16'h0000};
    if (op.shift < 0)
      shifted = wordIn <<< 6'(-op.shift);
    else
      shifted = wordIn >>> op.shift;
  end

  // Adder, overflow detect and clamp
  logic [39:0] src;
  logic [39:0] other;
  logic [39:0] addend;
  logic        useZero;
  logic        subtract;
  logic [40:0] sum;
  logic [39:0] res;
  logic [39:0] accNext;
  logic        ovf39;
  logic        ovf31;
  logic        guardRaw;
  logic        guardNext;
  logic        stickySet;
  logic        clampEn;
  logic        wide;
  always_comb begin
    src      = op.accSel ? accumulator_b_reg : accumulator_a_reg;
    other    = op.accSel ? accumulator_a_reg : accumulator_b_reg;
    addend   = product40;
    useZero  = 1'b0;
    subtract = 1'b0;
    case (op.kind)
      dmdd_pkg::OP_MSC:   subtract = 1'b1;
      dmdd_pkg::OP_MPY:   useZero = 1'b1;
      dmdd_pkg::OP_MPYN:  begin useZero = 1'b1; subtract = 1'b1; end
      dmdd_pkg::OP_ADDSH: addend = shifted;
      dmdd_pkg::OP_LOAD:  begin useZero = 1'b1; addend = shifted; end
      dmdd_pkg::OP_ADDAB: addend = other;
      dmdd_pkg::OP_SUBAB: begin addend = other; subtract = 1'b1; end
      dmdd_pkg::OP_NEG:   begin addend = src; useZero = 1'b1; subtract = 1'b1; end
      dmdd_pkg::OP_CLR:   begin addend = '0; useZero = 1'b1; end
      default:            ;
    endcase
    // Borrow is active low: subtracting feeds complement plus carry one
    sum = {1'b0, useZero ? 40'h0 : src} + {1'b0, subtract ? ~addend : addend}
          + {40'h0, subtract};
    sum[40] = (useZero ? 1'b0 : src[39]) ^ (subtract ? ~addend[39] : addend[39]) ^ sum[40];
    res      = sum[39:0];
    ovf39    = sum[40] != sum[39];
    ovf31    = ovf39 || !(&res[39:31] || ~|res[39:31]);
    guardRaw = !(&res[39:32] || ~|res[39:32]);
    clampEn  = op.accSel ? cfg_reg[dmdd_pkg::CFG_CLAMP_B_BIT]
                         : cfg_reg[dmdd_pkg::CFG_CLAMP_A_BIT];
    wide     = cfg_reg[dmdd_pkg::CFG_WIDTH_BIT];
    accNext   = res;
    guardNext = guardRaw;
    stickySet = 1'b0;
    if (clampEn && wide) begin
      if (ovf39) begin
        accNext   = sum[40] ? dmdd_pkg::MIN40 : dmdd_pkg::MAX40;
        stickySet = 1'b1;
      end
    end else if (clampEn) begin
      guardNext = 1'b0;
      if (ovf31) begin
        accNext   = sum[40] ? dmdd_pkg::MIN32 : dmdd_pkg::MAX32;
        stickySet = 1'b1;
      end
    end else begin
      stickySet = ovf39;
    end
  end

  // Accumulators written in the operation's own cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      accumulator_a_reg   <= '0;
      accumulator_b_reg   <= '0;
      guardA_reg <= 1'b0;
      guardB_reg <= 1'b0;
    end else if (isAcc) begin
      if (op.accSel) begin
        accumulator_b_reg   <= accNext;
        guardB_reg <= guardNext;
      end else begin
        accumulator_a_reg   <= accNext;
        guardA_reg <= guardNext;
      end
    end
  end

  // Stickies: a new overflow wins over a clearing write
  always_ff @(posedge clock) begin
    if (srst) begin
      clampA_reg <= 1'b0;
      clampB_reg <= 1'b0;
    end else begin
      clampA_reg <= (isAcc && !op.accSel && stickySet) ||
        (clampA_reg && !(stWrite && !regWdata[dmdd_pkg::ST_CLAMP_A_BIT]));
      clampB_reg <= (isAcc && op.accSel && stickySet) ||
        (clampB_reg && !(stWrite && !regWdata[dmdd_pkg::ST_CLAMP_B_BIT]));
    end
  end

  always_comb begin
    trapRequest = (guardA_reg && trap_reg[dmdd_pkg::TRAP_SPILL_A_BIT]) ||
                  (guardB_reg && trap_reg[dmdd_pkg::TRAP_SPILL_B_BIT]);
    // Wrap trap only while that accumulator is unclamped
    if (trap_reg[dmdd_pkg::TRAP_WRAP_BIT])
      trapRequest = trapRequest ||
        (clampA_reg && !cfg_reg[dmdd_pkg::CFG_CLAMP_A_BIT]) ||
        (clampB_reg && !cfg_reg[dmdd_pkg::CFG_CLAMP_B_BIT]);
  end

  // Integer multiply result
  always_ff @(posedge clock) begin
    if (srst)
      productReg <= '0;
    else if (opValid && op.kind == dmdd_pkg::OP_IMUL)
      productReg <= op.byteMode ? {16'h0000, mulFull[15:0]} : mulFull[31:0];
  end

  // Divider: restoring on magnitudes, sign fixed on the last step
  logic [31:0] dividend;
  logic        dividendNeg;
  logic        divSigned;
  logic [31:0] dividendMag;
  logic [15:0] divisorMag;
  logic [16:0] trial;
  logic [16:0] trialDiff;
  always_comb begin
    case (op.divKind)
      dmdd_pkg::DIV_FRAC:  dividend = {op.opA[15], op.opA, 15'h0000};
      dmdd_pkg::DIV_SLONG: dividend = {op.opHi, op.opA};
      dmdd_pkg::DIV_ULONG: dividend = {op.opHi, op.opA};
      dmdd_pkg::DIV_SWORD: dividend = {{16{op.opA[15]}}, op.opA};
      default:             dividend = {16'h0000, op.opA};
    endcase
    divSigned   = !(op.divKind inside {dmdd_pkg::DIV_ULONG, dmdd_pkg::DIV_UWORD});
    dividendNeg = divSigned && dividend[31];
    dividendMag = dividendNeg ? 32'(-dividend) : dividend;
    divisorMag  = (divSigned && op.opB[15]) ? 16'(-op.opB) : op.opB;
    trial       = {divRem_reg, divLow_reg[15]};
    trialDiff   = trial - {1'b0, divisor_reg};
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      divRem_reg   <= '0;
      divLow_reg   <= '0;
      divisor_reg  <= '0;
      negQuot_reg  <= 1'b0;
      negRem_reg   <= 1'b0;
      quotientReg  <= '0;
      remainderReg <= '0;
    end else if (isDiv) begin
      if (iterationCounter == dmdd_pkg::DIV_FIRST_ITER) begin
        divRem_reg  <= dividendMag[31:16];
        divLow_reg  <= dividendMag[15:0];
        divisor_reg <= divisorMag;
        negQuot_reg <= dividendNeg ^ (divSigned && op.opB[15]);
        negRem_reg  <= dividendNeg;
      end else if (iterationCounter == dmdd_pkg::DIV_LAST_ITER) begin
        quotientReg  <= negQuot_reg ? 16'(-divLow_reg) : divLow_reg;
        remainderReg <= negRem_reg ? 16'(-divRem_reg) : divRem_reg;
      end else if (iterationCounter < dmdd_pkg::DIV_FIRST_ITER) begin
        if (!trialDiff[16]) begin
          divRem_reg <= trialDiff[15:0];
          divLow_reg <= {divLow_reg[14:0], 1'b1};
        end else begin
          divRem_reg <= trial[15:0];
          divLow_reg <= {divLow_reg[14:0], 1'b0};
        end
      end
    end
  end

  // Register port
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_reg  <= dmdd_pkg::CFG_RESET;
      trap_reg <= dmdd_pkg::TRAP_RESET;
    end else if (regWrite) begin
      if (regAddr == dmdd_pkg::OFS_CORE_CONFIG)
        cfg_reg <= regWdata & dmdd_pkg::CFG_MASK;
      if (regAddr == dmdd_pkg::OFS_TRAP_CONTROL)
        trap_reg <= regWdata & dmdd_pkg::TRAP_MASK;
    end
  end

  assign coreConfig = cfg_reg;

  logic [15:0] status;
  always_comb begin
    status = '0;
    status[dmdd_pkg::ST_GUARD_A_BIT]   = guardA_reg;
    status[dmdd_pkg::ST_GUARD_B_BIT]   = guardB_reg;
    status[dmdd_pkg::ST_CLAMP_A_BIT]   = clampA_reg;
    status[dmdd_pkg::ST_CLAMP_B_BIT]   = clampB_reg;
    status[dmdd_pkg::ST_GUARD_ANY_BIT] = guardA_reg | guardB_reg;
    status[dmdd_pkg::ST_CLAMP_ANY_BIT] = clampA_reg | clampB_reg;
  end

  always_ff @(posedge clock) begin
    if (srst)
      regRdata <= '0;
    else if (regRead) begin
      case (regAddr)
        dmdd_pkg::OFS_CORE_CONFIG:  regRdata <= cfg_reg;
        dmdd_pkg::OFS_TRAP_CONTROL: regRdata <= trap_reg;
        dmdd_pkg::OFS_STATUS:       regRdata <= status;
        dmdd_pkg::OFS_QUOTIENT:     regRdata <= quotientReg;
        dmdd_pkg::OFS_REMAINDER:    regRdata <= remainderReg;
        dmdd_pkg::OFS_ACCUMULATOR_A_LO:      regRdata <= accumulator_a_reg[15:0];
        dmdd_pkg::OFS_ACCUMULATOR_A_HI:      regRdata <= accumulator_a_reg[31:16];
        dmdd_pkg::OFS_ACCUMULATOR_A_UP:      regRdata <= {8'h00, accumulator_a_reg[39:32]};
        dmdd_pkg::OFS_ACCUMULATOR_B_LO:      regRdata <= accumulator_b_reg[15:0];
        dmdd_pkg::OFS_ACCUMULATOR_B_HI:      regRdata <= accumulator_b_reg[31:16];
        dmdd_pkg::OFS_ACCUMULATOR_B_UP:      regRdata <= {8'h00, accumulator_b_reg[39:32]};
        dmdd_pkg::OFS_PRODUCT_LO:   regRdata <= productReg[15:0];
        dmdd_pkg::OFS_PRODUCT_HI:   regRdata <= productReg[31:16];
        default:                    regRdata <= 16'h0000;
      endcase
    end else
      regRdata <= 16'h0000;
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  quot_update_a: assert property ($changed(quotientReg) |->
    $past(isDiv && iterationCounter == dmdd_pkg::DIV_LAST_ITER))
    else $error("quotient changed outside last divide step");
  guard_track_a: assert property (isAcc && !op.accSel &&
    !cfg_reg[dmdd_pkg::CFG_CLAMP_A_BIT] |=>
    guardA_reg == !(&accumulator_a_reg[39:32] || ~|accumulator_a_reg[39:32]))
    else $error("guard flag disagrees with accumulator guard bits");
  sticky_hold_a: assert property ($fell(clampA_reg) |->
    $past(stWrite && !regWdata[dmdd_pkg::ST_CLAMP_A_BIT]))
    else $error("sticky fell without a clearing write");
  super_clamp_a: assert property ($rose(clampA_reg) &&
    $past(cfg_reg[dmdd_pkg::CFG_WIDTH_BIT] && cfg_reg[dmdd_pkg::CFG_CLAMP_A_BIT]) |->
    accumulator_a_reg == dmdd_pkg::MAX40 || accumulator_a_reg == dmdd_pkg::MIN40)
    else $error("40-bit clamp value wrong");
  narrow_clamp_a: assert property (isAcc && !op.accSel &&
    cfg_reg[dmdd_pkg::CFG_CLAMP_A_BIT] && !cfg_reg[dmdd_pkg::CFG_WIDTH_BIT] |=>
    !guardA_reg && (&accumulator_a_reg[39:31] || ~|accumulator_a_reg[39:31]))
    else $error("32-bit clamp left guard bits in use");
  wrap_value_a: assert property (isAcc && !op.accSel &&
    !cfg_reg[dmdd_pkg::CFG_CLAMP_A_BIT] |=> accumulator_a_reg == $past(res))
    else $error("wrap mode altered the sum");
  either_flag_a: assert property (regRead && regAddr == dmdd_pkg::OFS_STATUS |=>
    regRdata[dmdd_pkg::ST_CLAMP_ANY_BIT] == $past(clampA_reg || clampB_reg))
    else $error("combined clamp bit wrong");
  spill_trap_a: assert property (guardA_reg && trap_reg[dmdd_pkg::TRAP_SPILL_A_BIT]
    |-> trapRequest)
    else $error("guard spill did not request a trap");
  sticky_b_hold_a: assert property ($fell(clampB_reg) |->
    $past(stWrite && !regWdata[dmdd_pkg::ST_CLAMP_B_BIT]))
    else $error("sticky B fell without a clearing write");
  either_guard_a: assert property (regRead && regAddr == dmdd_pkg::OFS_STATUS |=>
    regRdata[dmdd_pkg::ST_GUARD_ANY_BIT] == $past(guardA_reg || guardB_reg))
    else $error("combined guard bit wrong");
  wrap_trap_a: assert property (trap_reg[dmdd_pkg::TRAP_WRAP_BIT] && clampB_reg &&
    !cfg_reg[dmdd_pkg::CFG_CLAMP_B_BIT] |-> trapRequest)
    else $error("wrap overflow did not request a trap");
  wrap_sticky_a: assert property (isAcc && op.accSel && ovf39 &&
    !cfg_reg[dmdd_pkg::CFG_CLAMP_B_BIT] |=> clampB_reg)
    else $error("wrap overflow left sticky clear");

  div_done_c: cover property (isDiv && iterationCounter == dmdd_pkg::DIV_LAST_ITER);
  super_sat_c: cover property ($rose(clampA_reg) && cfg_reg[dmdd_pkg::CFG_WIDTH_BIT]);
  narrow_sat_c: cover property ($rose(clampA_reg) && !cfg_reg[dmdd_pkg::CFG_WIDTH_BIT]);
  wrap_trap_c: cover property ($rose(trapRequest) && trap_reg[dmdd_pkg::TRAP_WRAP_BIT]);
endmodule : dmdd_core

// *** core/dmdd_pkg.sv ***
// Constants, encodings and carriers of the multiply, accumulate and divide datapath.
// Assumes one 50 MHz core clock shared with the decoder and register file.
package dmdd_pkg;
  localparam int CLK_HZ = 50_000_000;
  // Divide: 18 step executions counted 17 down to 0; the repeat setup adds one cycle
  localparam logic [4:0] DIV_FIRST_ITER = 5'h11;
  localparam logic [4:0] DIV_LAST_ITER  = 5'h00;
  // Register indices on the plain register port
  localparam logic [3:0] OFS_CORE_CONFIG  = 4'h0;
  localparam logic [3:0] OFS_TRAP_CONTROL = 4'h1;
  localparam logic [3:0] OFS_STATUS       = 4'h2;
  localparam logic [3:0] OFS_QUOTIENT     = 4'h3;
  localparam logic [3:0] OFS_REMAINDER    = 4'h4;
  localparam logic [3:0] OFS_ACCUMULATOR_A_LO      = 4'h5;
  localparam logic [3:0] OFS_ACCUMULATOR_A_HI      = 4'h6;
  localparam logic [3:0] OFS_ACCUMULATOR_A_UP      = 4'h7;
  localparam logic [3:0] OFS_ACCUMULATOR_B_LO      = 4'h8;
  localparam logic [3:0] OFS_ACCUMULATOR_B_HI      = 4'h9;
  localparam logic [3:0] OFS_ACCUMULATOR_B_UP      = 4'ha;
  localparam logic [3:0] OFS_PRODUCT_LO   = 4'hb;
  localparam logic [3:0] OFS_PRODUCT_HI   = 4'hc;
  // Core configuration fields
  localparam int CFG_INTEGER_BIT   = 0;
  localparam int CFG_ROUND_BIT     = 1;
  localparam int CFG_WIDTH_BIT     = 4;
  localparam int CFG_MEMCLAMP_BIT  = 5;
  localparam int CFG_CLAMP_B_BIT   = 6;
  localparam int CFG_CLAMP_A_BIT   = 7;
  localparam int CFG_UNSIGNED_BIT  = 12;
  localparam logic [15:0] CFG_MASK  = 16'h10f3;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Trap control fields
  localparam int TRAP_WRAP_BIT   = 8;
  localparam int TRAP_SPILL_B_BIT = 9;
  localparam int TRAP_SPILL_A_BIT = 10;
  localparam logic [15:0] TRAP_MASK  = 16'h0700;
  localparam logic [15:0] TRAP_RESET = 16'h0000;
  // Status fields; clamp stickies clear by writing zero
  localparam int ST_GUARD_A_BIT = 0;
  localparam int ST_GUARD_B_BIT = 1;
  localparam int ST_CLAMP_A_BIT = 2;
  localparam int ST_CLAMP_B_BIT = 3;
  localparam int ST_GUARD_ANY_BIT = 4;
  localparam int ST_CLAMP_ANY_BIT = 5;
  // Clamp values
  localparam logic [39:0] MAX40 = 40'h7fffffffff;
  localparam logic [39:0] MIN40 = 40'h8000000000;
  localparam logic [39:0] MAX32 = 40'h007fffffff;
  localparam logic [39:0] MIN32 = 40'hff80000000;

  typedef enum logic [3:0] {
    OP_NONE, OP_MAC, OP_MSC, OP_MPY, OP_MPYN, OP_ADDSH, OP_LOAD,
    OP_ADDAB, OP_SUBAB, OP_NEG, OP_CLR, OP_IMUL, OP_DIV
  } dmdd_opkind_t;

  typedef enum logic [2:0] {
    DIV_FRAC, DIV_SLONG, DIV_ULONG, DIV_SWORD, DIV_UWORD
  } dmdd_divkind_t;

  typedef struct packed {
    dmdd_opkind_t      kind;
    dmdd_divkind_t     divKind;
    logic              accSel;
    logic              aSigned;
    logic              bSigned;
    logic              byteMode;
    logic signed [5:0] shift;
    logic [15:0]       opA;
    logic [15:0]       opB;
    logic [15:0]       opHi;
  } dmdd_op_t;
endpackage : dmdd_pkg

// *** tb/dmdd_decoder_model.sv ***
// Stand-in for the decoder: issues one operation, or a counted divide loop.
// Assumes one request at a time, a one-cycle pulse, the next only after busy drops.
module dmdd_decoder_model (
  input  wire logic               clock,
  input  wire logic               srst,
  input  wire logic               reqValid,
  input  wire dmdd_pkg::dmdd_op_t reqOp,
  output logic                    busy,
  output logic                    opValid,
  output dmdd_pkg::dmdd_op_t      op,
  output logic [4:0]              iterationCounter
);
  timeunit 1ns;
  timeprecision 1ps;
  assign busy = reqValid | opValid;
  always_ff @(posedge clock) begin
    if (srst) begin
      opValid          <= 1'b0;
      op               <= '0;
      iterationCounter <= 5'h00;
    end else if (reqValid && !opValid) begin
      opValid <= 1'b1;
      op      <= reqOp;
      // Repeat loop of 18 steps, counter 17 down to 0
      iterationCounter <= (reqOp.kind == dmdd_pkg::OP_DIV) ? dmdd_pkg::DIV_FIRST_ITER : 5'h00;
    end else if (opValid && iterationCounter != 5'h00) begin
      iterationCounter <= iterationCounter - 5'h01;
    end else begin
      opValid          <= 1'b0;
      // Idle lines carry the stale operands, inverted every cycle
      op               <= dmdd_pkg::dmdd_op_t'(~op);
      iterationCounter <= ~iterationCounter;
    end
  end
endmodule : dmdd_decoder_model

// *** tb/dsp_mac_divide_datapath_test.sv ***
// Self-checking bench of the datapath: register port reads scored from a queue.
// Assumes the decoder model as operation source and a 50 MHz clock.
module dsp_mac_divide_datapath_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { logic [15:0] exp; logic [15:0] mask; } dmdd_note_t;
  logic clock, srst, reqValid, busy, opValid, regWrite, regRead, trapRequest, readSeen;
  dmdd_pkg::dmdd_op_t reqOp, op;
  logic [4:0]  iterationCounter;
  logic [3:0]  regAddr;
  logic [15:0] regWdata, regRdata, quotientReg, remainderReg, coreConfig;
  logic [31:0] productReg;
  int          fails, comparisons;
  dmdd_note_t  notes[$];
  dmdd_note_t  note;

  dmdd_decoder_model u_model (.clock(clock), .srst(srst), .reqValid(reqValid), .reqOp(reqOp),
    .busy(busy), .opValid(opValid), .op(op), .iterationCounter(iterationCounter));
  dmdd_core u_dut (.clock(clock), .srst(srst), .opValid(opValid), .op(op),
    .iterationCounter(iterationCounter), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .quotientReg(quotientReg),
    .remainderReg(remainderReg), .productReg(productReg), .coreConfig(coreConfig),
    .trapRequest(trapRequest));

  always #10 clock = ~clock;

  task automatic final_report;
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
    @(posedge clock);
    regRead  <= 1'b1;
    regWrite <= 1'b0;
    regAddr  <= a;
    notes.push_back('{e & m, m});
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regRead  <= 1'b0;
    regAddr  <= a;
    regWdata <= d;
  endtask : wr

  task automatic idle;
    @(posedge clock);
    regRead  <= 1'b0;
    regWrite <= 1'b0;
  endtask : idle

  task automatic doOp(input dmdd_pkg::dmdd_op_t o);
    int n;
    n = 0;
    idle();
    reqValid <= 1'b1;
    reqOp    <= o;
    @(posedge clock);
    reqValid <= 1'b0;
    #1;
    while (busy && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 40) fails++;
  endtask : doOp

  task automatic rdAcc(input logic acc, input logic [39:0] v);
    logic [3:0] base;
    base = acc ? dmdd_pkg::OFS_ACCUMULATOR_B_LO : dmdd_pkg::OFS_ACCUMULATOR_A_LO;
    rd(base, v[15:0]);
    rd(base + 4'h1, v[31:16]);
    rd(base + 4'h2, {8'h00, v[39:32]}, 16'h00ff);
  endtask : rdAcc

  task automatic trapIs(input logic [15:0] d, input logic e);
    wr(dmdd_pkg::OFS_TRAP_CONTROL, d);
    idle();
    @(posedge clock);
    #1;
    check("trapRequest", {15'h0000, trapRequest}, {15'h0000, e});
  endtask : trapIs

  function automatic dmdd_pkg::dmdd_op_t mk(input dmdd_pkg::dmdd_opkind_t k, input logic acc,
      input logic [15:0] a, input logic [15:0] b, input logic [15:0] h = 16'h0000,
      input dmdd_pkg::dmdd_divkind_t dk = dmdd_pkg::DIV_FRAC);
    dmdd_pkg::dmdd_op_t o;
    o = '0;
    o.kind = k;
    o.divKind = dk;
    o.accSel = acc;
    o.opA = a;
    o.opB = b;
    o.opHi = h;
    return o;
  endfunction : mk

  // Product of 17-bit extended operands, sign-extended to 40 bits
  function automatic logic [39:0] mulx(input logic [15:0] a, input logic [15:0] b,
      input logic sa, input logic sb);
    logic signed [16:0] x, y;
    logic signed [33:0] p;
    x = {sa & a[15], a};
    y = {sb & b[15], b};
    p = x * y;
    return {{6{p[33]}}, p};
  endfunction : mulx

  always @(posedge clock) readSeen <= regRead;
  always @(negedge clock) begin
    if (readSeen && !srst) begin
      if (notes.size() == 0) begin
        fails++;
      end else begin
        note = notes.pop_front();
        check("regRdata", regRdata & note.mask, note.exp);
      end
    end else if (!srst) begin
      check("regRdata idle", regRdata, 16'h0000);
    end
  end

  initial begin
    #600us;
    fails++;
    final_report();
  end

  initial begin
    logic [15:0] a, b, h;
    logic [39:0] p;
    logic s;
    int sd;
    longint lv;
    dmdd_pkg::dmdd_op_t o;
    dmdd_pkg::dmdd_divkind_t dk;
    {clock, regRead, regWrite, reqValid} = '0;
    srst = 1'b1;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    reqOp = '0;
    void'($urandom(32'h5921b28f));
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    rd(dmdd_pkg::OFS_CORE_CONFIG, dmdd_pkg::CFG_RESET);
    rd(dmdd_pkg::OFS_TRAP_CONTROL, dmdd_pkg::TRAP_RESET);
    rd(dmdd_pkg::OFS_STATUS, 16'h0000);
    rd(4'hf, 16'h0000);
    wr(dmdd_pkg::OFS_CORE_CONFIG, 16'hffff);
    wr(dmdd_pkg::OFS_TRAP_CONTROL, 16'hffff);
    wr(4'hd, 16'hffff);
    rd(dmdd_pkg::OFS_CORE_CONFIG, dmdd_pkg::CFG_MASK);
    rd(dmdd_pkg::OFS_TRAP_CONTROL, dmdd_pkg::TRAP_MASK);
    rd(4'hd, 16'h0000);
    for (int m = 0; m < 3; m++) begin
      wr(dmdd_pkg::OFS_CORE_CONFIG, (m == 0) ? 16'h0000 : (m == 1) ? 16'h0001 : 16'h1001);
      for (int i = 0; i < 4; i++) begin
        a = (i == 0) ? 16'h8000 : 16'($urandom);
        b = (i == 0) ? 16'h8000 : 16'($urandom);
        p = mulx(a, b, m != 2, m != 2);
        if (m == 0) p = p << 1;
        doOp(mk(dmdd_pkg::OP_MPY, i[0], a, b));
        rdAcc(i[0], p);
      end
    end
    for (int i = 0; i < 5; i++) begin
      o = mk(dmdd_pkg::OP_IMUL, 1'b0, 16'($urandom), 16'($urandom));
      o.aSigned = 1'($urandom);
      o.bSigned = i[0];
      o.byteMode = (i == 4);
      // Byte operands take part as extended low bytes only
      a = o.byteMode ? {{8{o.aSigned & o.opA[7]}}, o.opA[7:0]} : o.opA;
      b = o.byteMode ? {{8{o.bSigned & o.opB[7]}}, o.opB[7:0]} : o.opB;
      p = mulx(a, b, o.aSigned, o.bSigned);
      doOp(o);
      rd(dmdd_pkg::OFS_PRODUCT_LO, p[15:0]);
      rd(dmdd_pkg::OFS_PRODUCT_HI, (i == 4) ? 16'h0000 : p[31:16]);
    end
    for (int k = 0; k < 10; k++) begin
      a = 16'($urandom) & 16'h3fff;
      b = (16'($urandom) & 16'h7fff) | 16'h4000;
      h = 16'($urandom) & 16'h1fff;
      dk = dmdd_pkg::dmdd_divkind_t'(k % 5);
      s = 1'($urandom) & (dk != dmdd_pkg::DIV_ULONG) & (dk != dmdd_pkg::DIV_UWORD);
      if (s) begin
        a = ~a;
        h = ~h;
      end
      case (dk)
        dmdd_pkg::DIV_FRAC:  sd = int'($signed(a)) * 32768;
        dmdd_pkg::DIV_SLONG: sd = $signed({h, a});
        dmdd_pkg::DIV_ULONG: sd = int'({h, a});
        default:             sd = (dk == dmdd_pkg::DIV_SWORD) ? int'($signed(a)) : int'(a);
      endcase
      doOp(mk(dmdd_pkg::OP_DIV, 1'b0, a, b, h, dk));
      rd(dmdd_pkg::OFS_QUOTIENT, 16'(sd / int'(b)));
      rd(dmdd_pkg::OFS_REMAINDER, 16'(sd % int'(b)));
    end
    // Shifted load and add, negate, multiply-negate, then the accumulator-to-accumulator forms
    wr(dmdd_pkg::OFS_CORE_CONFIG, 16'h0000);
    a = 16'($urandom);
    b = 16'($urandom);
    lv = longint'($signed(a)) * 65536;
    o = mk(dmdd_pkg::OP_LOAD, 1'b0, a, 16'h0000);
    o.shift = 6'sd3;
    doOp(o);
    rdAcc(1'b0, 40'(lv >>> 3));
    o.kind = dmdd_pkg::OP_ADDSH;
    o.shift = -6'sd4;
    doOp(o);
    lv = (lv >>> 3) + lv * 16;
    rdAcc(1'b0, 40'(lv));
    doOp(mk(dmdd_pkg::OP_NEG, 1'b0, a, b));
    rdAcc(1'b0, 40'(-lv));
    doOp(mk(dmdd_pkg::OP_MPYN, 1'b1, a, b));
    p = 40'h0 - (mulx(a, b, 1'b1, 1'b1) << 1);
    rdAcc(1'b1, p);
    doOp(mk(dmdd_pkg::OP_ADDAB, 1'b0, a, b));
    rdAcc(1'b0, 40'(p - lv));
    doOp(mk(dmdd_pkg::OP_SUBAB, 1'b1, a, b));
    rdAcc(1'b1, 40'(lv));
    wr(dmdd_pkg::OFS_CORE_CONFIG, 16'h0080);
    doOp(mk(dmdd_pkg::OP_CLR, 1'b0, 16'h0000, 16'h0000));
    doOp(mk(dmdd_pkg::OP_MAC, 1'b0, 16'h8000, 16'h8000));
    rdAcc(1'b0, dmdd_pkg::MAX32);
    rd(dmdd_pkg::OFS_STATUS, 16'h0024, 16'h0025);
    doOp(mk(dmdd_pkg::OP_CLR, 1'b0, 16'h0000, 16'h0000));
    doOp(mk(dmdd_pkg::OP_MSC, 1'b0, 16'h8000, 16'h8000));
    rdAcc(1'b0, 40'hff80000000);
    doOp(mk(dmdd_pkg::OP_MSC, 1'b0, 16'h8000, 16'h8000));
    rdAcc(1'b0, dmdd_pkg::MIN32);
    wr(dmdd_pkg::OFS_CORE_CONFIG, 16'h0090);
    wr(dmdd_pkg::OFS_STATUS, 16'h0000);
    doOp(mk(dmdd_pkg::OP_CLR, 1'b0, 16'h0000, 16'h0000));
    doOp(mk(dmdd_pkg::OP_CLR, 1'b1, 16'h0000, 16'h0000));
    // 256 full-scale steps reach bit 39 on both accumulators
    for (int i = 0; i < 512; i++) doOp(mk(dmdd_pkg::OP_MAC, i[0], 16'h8000, 16'h8000));
    rdAcc(1'b0, dmdd_pkg::MAX40);
    rdAcc(1'b1, dmdd_pkg::MIN40);
    rd(dmdd_pkg::OFS_STATUS, 16'h003f, 16'h003f);
    trapIs(16'h0000, 1'b0);
    trapIs(16'h0100, 1'b1);
    trapIs(16'h0400, 1'b1);
    wr(dmdd_pkg::OFS_STATUS, 16'h0000);
    rd(dmdd_pkg::OFS_STATUS, 16'h0000, 16'h002c);
    trapIs(16'h0100, 1'b0);
    doOp(mk(dmdd_pkg::OP_CLR, 1'b0, 16'h0000, 16'h0000));
    rd(dmdd_pkg::OFS_STATUS, 16'h0000, 16'h002d);
    idle();
    repeat (4) @(posedge clock);
    if (notes.size() != 0) fails++;
    final_report();
  end
endmodule : dsp_mac_divide_datapath_test
